//--- dubr_pkg.sv
// Purpose: Shared constants and types of the debug unlock, break and runtime block.
// Assumes: pclk at 25 MHz, APB register access, 32-bit data words.
// Notes: Register offsets are byte addresses of aligned words.
//
// Overview of operation
// - Small package pin locked until unlock done
// - Unlock missed during reset means GPIO only
// - Correct key plus release makes pin debug pin
// - Break opcode 00H enters debug and idles processor
// - Breaks disabled: opcode acts as no-operation
// - Flash pages 512 bytes, 8 rows of 64
// - 16-bit runtime counter counts clocks between breaks
// - Counter starts on leaving debug, saturates FFFFH
// - Status bit 7 shows debug mode
// - Status bit 6 shows processor halt mode
// - Status bit 5 shows read protect honor flag
// - Status bits 4 to 0 read zero

package dubr_pkg;

  // ******************************************************************
  // Timing.
  // ******************************************************************
  localparam int unsigned CLK_HZ = 25_000_000; // System clock rate.
  localparam int unsigned RST_WAIT_MS = 5; // Internal reset sequence time.
  // Least wait, rounded up to whole cycles.
  localparam int unsigned RST_WAIT_CYC = (RST_WAIT_MS * CLK_HZ + 999) / 1000;

  // ******************************************************************
  // Serial unlock bytes and opcodes.
  // ******************************************************************
  localparam logic [7:0] AUTOBAUD_BYTE = 8'h80; // Low for start plus seven bits.
  localparam int unsigned AUTOBAUD_SHIFT = 3; // Low time spans eight bit times.
  localparam logic [31:0] UNLOCK_KEY = 32'hEB5A70CD; // Sent first byte first.
  localparam logic [1:0] KEY_LAST = 2'h3; // Index of the last key byte.
  localparam logic [7:0] BREAK_OPCODE = 8'h00; // Break instruction opcode.
  localparam int unsigned BAUD_W = 16; // Width of bit period counters.

  // ******************************************************************
  // Flash page geometry.
  // ******************************************************************
  localparam int unsigned PAGE_BYTES = 512; // Smallest erasable unit.
  localparam int unsigned PAGE_ROWS = 8; // Rows in one page.
  localparam int unsigned ROW_BYTES = PAGE_BYTES / PAGE_ROWS; // 64 bytes a row.
  localparam int unsigned PAGE_LSB = $clog2(PAGE_BYTES); // Offset bits in a page.
  localparam int unsigned FLASH_AW = 13; // Byte address width of flash.

  // ******************************************************************
  // Register map.
  // ******************************************************************
  localparam logic [11:0] OFF_STATUS = 12'h000; // Debug status, read only.
  localparam logic [11:0] OFF_CTRL = 12'h004; // Debug mode and break enable.
  localparam logic [11:0] OFF_RUNTIME = 12'h008; // Runtime counter, read only.
  localparam logic [11:0] OFF_IRQ_STAT = 12'h00C; // Sticky events, write one clears.
  localparam logic [11:0] OFF_IRQ_MASK = 12'h010; // Event enables.
  localparam logic [11:0] OFF_UNLOCK = 12'h014; // Unlock state, read only.

  localparam int unsigned ST_DBG = 7; // Status: debug mode.
  localparam int unsigned ST_HALT = 6; // Status: halt mode.
  localparam int unsigned ST_RPHON = 5; // Status: read protect honor flag.
  localparam logic [4:0] ST_RSVD = 5'h00; // Status: reserved field value.
  localparam int unsigned CTRL_DBG = 7; // Control: debug mode.
  localparam int unsigned CTRL_BRKEN = 6; // Control: breakpoints enabled.
  localparam int unsigned UL_UNLOCKED = 0; // Unlock register: pin unlocked.
  localparam int unsigned UL_KEYFAIL = 1; // Unlock register: last key failed.

  localparam int unsigned EV_W = 4; // Number of interrupt events.
  localparam int unsigned EV_BREAK = 0; // Break taken into debug mode.
  localparam int unsigned EV_UNLOCK = 1; // Pin unlocked.
  localparam int unsigned EV_KEYFAIL = 2; // Unlock attempt failed.
  localparam int unsigned EV_RTSAT = 3; // Runtime counter saturated.

  // ******************************************************************
  // State encodings.
  // ******************************************************************
  typedef enum logic [2:0] {
    RX_HUNT = 3'b000, RX_MEAS = 3'b001, RX_IDLE = 3'b010,
    RX_START = 3'b011, RX_DATA = 3'b100, RX_STOP = 3'b101
  } dubr_rx_state_t;

  typedef enum logic [2:0] {
    UL_IDLE = 3'b000, UL_WAIT = 3'b001, UL_KEY = 3'b010,
    UL_OK = 3'b011, UL_FAIL = 3'b100
  } dubr_ul_state_t;

endpackage

//--- dubr_serial_rx.sv
// Purpose: Autobaud measurement and byte reception on the debug pin.
// Assumes: rx is already synchronised to pclk; idle level is high.
// Notes: The first low span after enable is the autobaud byte and yields no byte.
`timescale 1ns/1ns
module dubr_serial_rx (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and serial line.
  input wire logic enable,
  input wire logic rx,
  // Received bytes.
  output logic byte_valid,
  output logic [7:0] byte_data
);

  typedef struct packed {
    dubr_pkg::dubr_rx_state_t state; // Receiver state.
    logic [dubr_pkg::BAUD_W-1:0] cnt; // Cycle counter.
    logic [dubr_pkg::BAUD_W-1:0] period; // Measured bit period.
    logic [2:0] bits; // Data bit index.
    logic [7:0] shreg; // Shift register, low bit first.
    logic valid; // Byte strobe.
    logic [7:0] data; // Last byte.
  } dubr_rx_t;

  dubr_rx_t s_q;
  dubr_rx_t s_d;

  // Next state: measure the autobaud low span, then frame bytes.
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (!enable) begin
      // Disabled: forget the rate and wait for a new autobaud byte.
      s_d.state = dubr_pkg::RX_HUNT;
      s_d.cnt = '0;
    end else begin
      case (s_q.state)
        dubr_pkg::RX_HUNT: begin
          // Wait for the start of the autobaud byte.
          if (!rx) begin
            s_d.state = dubr_pkg::RX_MEAS;
            s_d.cnt = dubr_pkg::BAUD_W'(1);
          end
        end
        dubr_pkg::RX_MEAS: begin
          // The low span covers eight bit times.
          if (rx) begin
            s_d.period = s_q.cnt >> dubr_pkg::AUTOBAUD_SHIFT;
            s_d.state = dubr_pkg::RX_IDLE;
          end else if (s_q.cnt != '1) begin
            s_d.cnt = s_q.cnt + dubr_pkg::BAUD_W'(1);
          end
        end
        dubr_pkg::RX_IDLE: begin
          // Wait for a start bit.
          if (!rx) begin
            s_d.state = dubr_pkg::RX_START;
            s_d.cnt = '0;
          end
        end
        dubr_pkg::RX_START: begin
          // Check the start bit at its middle; a glitch returns to idle.
          s_d.cnt = s_q.cnt + dubr_pkg::BAUD_W'(1);
          if (s_q.cnt >= (s_q.period >> 1)) begin
            s_d.cnt = '0;
            s_d.bits = '0;
            s_d.state = rx ? dubr_pkg::RX_IDLE : dubr_pkg::RX_DATA;
          end
        end
        dubr_pkg::RX_DATA: begin
          // Sample one data bit per period.
          s_d.cnt = s_q.cnt + dubr_pkg::BAUD_W'(1);
          if (s_q.cnt >= s_q.period) begin
            s_d.cnt = '0;
            s_d.shreg = {rx, s_q.shreg[7:1]};
            s_d.bits = s_q.bits + 3'h1;
            if (s_q.bits == 3'h7) begin
              s_d.state = dubr_pkg::RX_STOP;
            end
          end
        end
        default: begin
          // Stop bit: a low stop bit is a framing error and is dropped.
          s_d.cnt = s_q.cnt + dubr_pkg::BAUD_W'(1);
          if (s_q.cnt >= s_q.period) begin
            s_d.state = dubr_pkg::RX_IDLE;
            s_d.valid = rx;
            s_d.data = rx ? s_q.shreg : s_q.data;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign byte_valid = s_q.valid;
  assign byte_data = s_q.data;

endmodule

//--- dubr_runtime.sv
// Purpose: Saturating runtime counter of clock cycles outside debug mode.
// Assumes: debug_mode comes from logic on pclk.
// Notes: The count restarts from zero each time debug mode is left.
`timescale 1ns/1ns
module dubr_runtime #(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Debug mode level.
  input wire logic debug_mode,
  // Count and saturation pulse.
  output logic [CNT_W-1:0] count,
  output logic saturated
);

  typedef struct packed {
    logic prev; // Debug mode one cycle ago.
    logic [CNT_W-1:0] cnt; // Running count.
    logic sat; // Saturation strobe.
  } dubr_rt_t;

  dubr_rt_t s_q;
  dubr_rt_t s_d;

  // Count while running, restart on leaving debug, hold at the top.
  always_comb begin
    s_d = s_q;
    s_d.prev = debug_mode;
    s_d.sat = 1'b0;
    if (debug_mode) begin
      s_d.cnt = s_q.cnt;
    end else if (s_q.prev) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != '1) begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
      s_d.sat = (s_d.cnt == '1);
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign saturated = s_q.sat;

endmodule

//--- dubr_top.sv
// Purpose: Debug pin unlock, break handling, runtime count and status registers.
// Assumes: APB slave with zero wait states; pins synchronised here.
// Notes: SMALL_PKG selects the shared pin behaviour of the smallest package.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
module dubr_top #(
  parameter bit SMALL_PKG = 1'b1,
  parameter int unsigned RST_WAIT = dubr_pkg::RST_WAIT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared pins.
  input wire logic shared_reset_pin_n,
  input wire logic shared_gpio_debug_pin_i,
  output logic shared_gpio_debug_pin_o,
  output logic shared_gpio_debug_pin_oe,
  // GPIO and debugger serial paths.
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic debug_tx,
  input wire logic debug_tx_oe,
  output logic debug_rx,
  // Processor side.
  input wire logic cpu_decode_valid,
  input wire logic [7:0] cpu_opcode,
  input wire logic cpu_halt,
  input wire logic read_protect_honor_flag,
  output logic cpu_idle,
  output logic break_as_nop,
  // Flash page erase.
  input wire logic flash_erase_req,
  input wire logic [dubr_pkg::FLASH_AW-1:0] flash_addr,
  output logic flash_erase_strobe,
  output logic [dubr_pkg::FLASH_AW-1:0] flash_erase_page_base,
  // Interrupt.
  output logic irq
);

  // ******************************************************************
  // State.
  // ******************************************************************
  typedef struct packed {
    logic rp_s1; // Reset pin, first synchroniser stage.
    logic rp_s2; // Reset pin, synchronised.
    logic px_s1; // Debug pin, first synchroniser stage.
    logic px_s2; // Debug pin, synchronised.
    dubr_pkg::dubr_ul_state_t ul; // Unlock sequence state.
    logic [16:0] wait_cnt; // Internal reset wait counter.
    logic [1:0] key_idx; // Next key byte index.
    logic unlocked; // Shared pin acts as debug pin.
    logic key_fail; // Last attempt failed.
    logic dbg; // Debug mode.
    logic brk_en; // Breakpoints enabled.
    logic nop; // Break ignored strobe.
    logic [dubr_pkg::EV_W-1:0] irq_stat; // Sticky events.
    logic [dubr_pkg::EV_W-1:0] irq_mask; // Event enables.
    logic [31:0] rdata; // Read data.
    logic erase; // Erase strobe.
    logic [dubr_pkg::FLASH_AW-1:0] erase_base; // Page base address.
  } dubr_top_t;

  dubr_top_t s_q;
  dubr_top_t s_d;

  logic rx_valid; // Received key byte strobe.
  logic [7:0] rx_data; // Received key byte.
  logic [15:0] rt_count; // Runtime count.
  logic rt_sat; // Runtime counter reached the top.
  logic [7:0] status; // Debug status register value.
  logic pin_debug; // Shared pin serves the debugger.
  logic brk_seen; // Break opcode decoded this cycle.
  logic wr_acc; // APB write access phase.
  logic mapped; // Address hits a register.
  logic [dubr_pkg::EV_W-1:0] events; // Event pulses this cycle.
  localparam logic [16:0] WAIT_LAST = 17'(RST_WAIT - 1); // Last wait count.

  // ******************************************************************
  // Sub blocks.
  // ******************************************************************
  dubr_serial_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(s_q.ul == dubr_pkg::UL_KEY),
    .rx(s_q.px_s2),
    .byte_valid(rx_valid),
    .byte_data(rx_data)
  );

  dubr_runtime #(.CNT_W(16)) u_rt (
    .pclk(pclk),
    .presetn(presetn),
    .debug_mode(s_q.dbg),
    .count(rt_count),
    .saturated(rt_sat)
  );

  // ******************************************************************
  // Combinational views.
  // ******************************************************************
  // Status word: debug, halt, honor flag, reserved zeros.
  assign status = {s_q.dbg, cpu_halt, read_protect_honor_flag, dubr_pkg::ST_RSVD};
  assign pin_debug = !SMALL_PKG || s_q.unlocked;
  assign brk_seen = cpu_decode_valid && (cpu_opcode == dubr_pkg::BREAK_OPCODE);
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == dubr_pkg::OFF_STATUS) || (paddr == dubr_pkg::OFF_CTRL) ||
                  (paddr == dubr_pkg::OFF_RUNTIME) || (paddr == dubr_pkg::OFF_IRQ_STAT) ||
                  (paddr == dubr_pkg::OFF_IRQ_MASK) || (paddr == dubr_pkg::OFF_UNLOCK);

  // ******************************************************************
  // Next state.
  // ******************************************************************
  always_comb begin
    s_d = s_q;
    events = '0;
    s_d.rp_s1 = shared_reset_pin_n;
    s_d.rp_s2 = s_q.rp_s1;
    s_d.px_s1 = shared_gpio_debug_pin_i;
    s_d.px_s2 = s_q.px_s1;
    s_d.nop = 1'b0;
    s_d.erase = 1'b0;

    // Unlock sequence, run while the shared reset pin is low.
    case (s_q.ul)
      dubr_pkg::UL_IDLE: begin
        if (!s_q.rp_s2) begin
          s_d.ul = dubr_pkg::UL_WAIT;
          s_d.wait_cnt = '0;
          s_d.unlocked = 1'b0;
        end
      end
      dubr_pkg::UL_WAIT: begin
        // Bytes before the internal reset sequence ends are not heard.
        if (s_q.rp_s2) begin
          s_d.ul = dubr_pkg::UL_IDLE;
        end else if (s_q.wait_cnt == WAIT_LAST) begin
          s_d.ul = dubr_pkg::UL_KEY;
          s_d.key_idx = '0;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt + 17'h00001;
        end
      end
      dubr_pkg::UL_KEY: begin
        if (s_q.rp_s2) begin
          // Release before the key finished leaves the pin as GPIO.
          s_d.ul = dubr_pkg::UL_IDLE;
          s_d.key_fail = 1'b1;
          events[dubr_pkg::EV_KEYFAIL] = 1'b1;
        end else if (rx_valid) begin
          if (rx_data == dubr_pkg::UNLOCK_KEY[31 - 8 * s_q.key_idx -: 8]) begin
            s_d.key_idx = s_q.key_idx + 2'h1;
            if (s_q.key_idx == dubr_pkg::KEY_LAST) begin
              s_d.ul = dubr_pkg::UL_OK;
            end
          end else begin
            s_d.ul = dubr_pkg::UL_FAIL;
          end
        end
      end
      dubr_pkg::UL_OK: begin
        // Key accepted: the pin turns into the debug pin on release.
        if (s_q.rp_s2) begin
          s_d.ul = dubr_pkg::UL_IDLE;
          s_d.unlocked = 1'b1;
          s_d.key_fail = 1'b0;
          events[dubr_pkg::EV_UNLOCK] = 1'b1;
        end
      end
      default: begin
        // Wrong key: stay locked until the next reset.
        if (s_q.rp_s2) begin
          s_d.ul = dubr_pkg::UL_IDLE;
          s_d.key_fail = 1'b1;
          events[dubr_pkg::EV_KEYFAIL] = 1'b1;
        end
      end
    endcase

    // Control register writes; a break in the same cycle wins.
    if (wr_acc && (paddr == dubr_pkg::OFF_CTRL)) begin
      s_d.dbg = pwdata[dubr_pkg::CTRL_DBG];
      s_d.brk_en = pwdata[dubr_pkg::CTRL_BRKEN];
    end
    if (brk_seen && !s_q.dbg) begin
      if (s_q.brk_en) begin
        s_d.dbg = 1'b1;
        events[dubr_pkg::EV_BREAK] = 1'b1;
      end else begin
        s_d.nop = 1'b1;
      end
    end
    events[dubr_pkg::EV_RTSAT] = rt_sat;

    // Interrupt status: a new event wins over a clear.
    if (wr_acc && (paddr == dubr_pkg::OFF_IRQ_STAT)) begin
      s_d.irq_stat = s_q.irq_stat & ~pwdata[dubr_pkg::EV_W-1:0];
    end
    s_d.irq_stat = s_d.irq_stat | events;
    if (wr_acc && (paddr == dubr_pkg::OFF_IRQ_MASK)) begin
      s_d.irq_mask = pwdata[dubr_pkg::EV_W-1:0];
    end

    // Read data is captured in the setup phase.
    if (psel && !penable) begin
      if (paddr == dubr_pkg::OFF_STATUS) begin
        s_d.rdata = {24'h000000, status};
      end else if (paddr == dubr_pkg::OFF_CTRL) begin
        s_d.rdata = 32'h00000000;
        s_d.rdata[dubr_pkg::CTRL_DBG] = s_q.dbg;
        s_d.rdata[dubr_pkg::CTRL_BRKEN] = s_q.brk_en;
      end else if (paddr == dubr_pkg::OFF_RUNTIME) begin
        s_d.rdata = {16'h0000, rt_count};
      end else if (paddr == dubr_pkg::OFF_IRQ_STAT) begin
        s_d.rdata = 32'(s_q.irq_stat);
      end else if (paddr == dubr_pkg::OFF_IRQ_MASK) begin
        s_d.rdata = 32'(s_q.irq_mask);
      end else if (paddr == dubr_pkg::OFF_UNLOCK) begin
        s_d.rdata = 32'({s_q.key_fail, s_q.unlocked});
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end

    // Page erase: the page is the smallest erasable unit.
    if (flash_erase_req) begin
      s_d.erase = 1'b1;
      s_d.erase_base = {flash_addr[dubr_pkg::FLASH_AW-1:dubr_pkg::PAGE_LSB],
                        dubr_pkg::PAGE_LSB'(0)};
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      // Pins idle high, so the synchronisers start high and no false low follows reset.
      s_q.rp_s1 <= 1'b1;
      s_q.rp_s2 <= 1'b1;
      s_q.px_s1 <= 1'b1;
      s_q.px_s2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************************
  // Outputs.
  // ******************************************************************
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign shared_gpio_debug_pin_o = pin_debug ? debug_tx : gpio_out;
  assign shared_gpio_debug_pin_oe = pin_debug ? debug_tx_oe : gpio_oe;
  assign debug_rx = pin_debug ? s_q.px_s2 : 1'b1;
  assign cpu_idle = s_q.dbg;
  assign break_as_nop = s_q.nop;
  assign flash_erase_strobe = s_q.erase;
  assign flash_erase_page_base = s_q.erase_base;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_on;
    brk_seen && !s_q.dbg && s_q.brk_en;
  endsequence

  property p_brk_enters;
    s_brk_on |=> s_q.dbg && cpu_idle && s_q.irq_stat[dubr_pkg::EV_BREAK];
  endproperty
  a_brk_enters: assert property (p_brk_enters) else $error("break did not enter debug");

  property p_brk_nop;
    brk_seen && !s_q.dbg && !s_q.brk_en && !wr_acc |=> break_as_nop && !s_q.dbg;
  endproperty
  a_brk_nop: assert property (p_brk_nop) else $error("disabled break not a nop");

  property p_locked_gpio;
    SMALL_PKG && !s_q.unlocked |-> debug_rx && (shared_gpio_debug_pin_oe == gpio_oe);
  endproperty
  a_locked_gpio: assert property (p_locked_gpio) else $error("locked pin reached debugger");

  property p_fail_stays;
    s_q.ul == dubr_pkg::UL_FAIL && s_q.rp_s2 |=> !s_q.unlocked && s_q.key_fail;
  endproperty
  a_fail_stays: assert property (p_fail_stays) else $error("wrong key unlocked pin");

  property p_unlock;
    s_q.ul == dubr_pkg::UL_OK && s_q.rp_s2 |=> s_q.unlocked ##1 pin_debug;
  endproperty
  a_unlock: assert property (p_unlock) else $error("good key did not unlock");

  property p_rt_inc;
    !s_q.dbg && !$past(s_q.dbg) && rt_count != 16'hFFFF |=> rt_count == $past(rt_count) + 16'h0001;
  endproperty
  a_rt_inc: assert property (p_rt_inc) else $error("runtime did not count");

  property p_rt_sat;
    rt_count == 16'hFFFF && !s_q.dbg && !$past(s_q.dbg) |=> rt_count == 16'hFFFF;
  endproperty
  a_rt_sat: assert property (p_rt_sat) else $error("runtime wrapped");

  property p_rt_hold;
    s_q.dbg [*2] |=> rt_count == $past(rt_count);
  endproperty
  a_rt_hold: assert property (p_rt_hold) else $error("runtime ran in debug");

  property p_status;
    psel && !penable && paddr == dubr_pkg::OFF_STATUS |=>
      prdata[7:0] == {$past(s_q.dbg), $past(cpu_halt), $past(read_protect_honor_flag), 5'h00};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_page;
    flash_erase_req |=> flash_erase_strobe && flash_erase_page_base[8:0] == 9'h000;
  endproperty
  a_page: assert property (p_page) else $error("erase not page aligned");

endmodule

//--- dubr_host.sv
// Purpose: Debug host model that drives the shared reset pin and the serial debug line.
// Assumes: Idle line level is high; 32 clock cycles per bit.
// Notes: The bench calls unlock with the key it wants to send.
`timescale 1ns/1ns
module dubr_host (
  // Clock.
  input wire logic pclk,
  // Shared pins driven by the host.
  output logic rst_n,
  output logic line
);
  initial begin
    rst_n = 1'b1;
    line = 1'b1;
  end
  // Sends one 8N1 frame, LSB first, then leaves the line idle high.
  task automatic tx(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (32) @(posedge pclk);
    end
  endtask
  // Holds reset, waits, sends autobaud and key, then releases reset.
  task automatic unlock(input logic [31:0] k);
    rst_n <= 1'b0;
    repeat (40) @(posedge pclk);
    tx(8'h80);
    for (int j = 3; j >= 0; j--) tx(k[j*8+:8]);
    rst_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  // Parks the serial line at a level long enough to pass the synchroniser.
  task automatic level(input logic v);
    line <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule

//--- dubr_top_test.sv
// Purpose: Self-checking bench of the debug unlock, break and runtime block.
// Assumes: Host model drives the shared pins; APB tasks below.
// Notes: Reset wait is shortened to 20 cycles.
`timescale 1ns/1ns
module dubr_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, a;
  logic pready, pslverr, po, poe, dv = 0, halt = 0, hon = 0, idle, nop, er = 0, es, irq;
  logic gout = 1, dtx = 0, goe = 0, drx, line, rstn;
  logic [7:0] op = 0;
  logic [12:0] fa = 0, fb;
  int miscompares = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  dubr_host h(.pclk(pclk), .rst_n(rstn), .line(line));
  dubr_top #(.RST_WAIT(20)) uut(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shared_reset_pin_n(rstn),
    .shared_gpio_debug_pin_i(poe ? po : line), .shared_gpio_debug_pin_o(po),
    .shared_gpio_debug_pin_oe(poe), .gpio_out(gout), .gpio_oe(goe), .debug_tx(dtx),
    .debug_tx_oe(1'b0), .debug_rx(drx), .cpu_decode_valid(dv), .cpu_opcode(op),
    .cpu_halt(halt), .read_protect_honor_flag(hon), .cpu_idle(idle), .break_as_nop(nop),
    .flash_erase_req(er), .flash_addr(fa), .flash_erase_strobe(es),
    .flash_erase_page_base(fb), .irq(irq));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin miscompares++; close_out(); end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(logic [7:0] o, logic e, logic [12:0] f);
    @(posedge pclk);
    dv <= ~e; op <= o; er <= e; fa <= f;
    @(posedge pclk);
    dv <= 0; er <= 0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(0, 12'h000, 0); chk("status", 32'h0, rd);
    apb(0, 12'h014, 0); chk("unlock", 32'h0, rd);
    chk("pin gpio", 32'h1, 32'(po));
    goe <= 1; h.level(1'b1); chk("oe gpio", 32'h1, 32'(poe));
    goe <= 0; h.level(1'b0); chk("rx locked", 32'h1, 32'(drx));
    h.level(1'b1);
    apb(0, 12'h020, 0); chk("slverr", 32'h1, 32'(err));
    $display("reset test done");
  endtask
  task automatic t_key();
    h.unlock(32'hEB5A70CE);
    apb(0, 12'h014, 0); chk("bad key", 32'h2, rd);
    chk("pin gpio", 32'h1, 32'(po));
    apb(1, 12'h010, 32'h2); apb(0, 12'h00C, 0); chk("events", 32'h4, rd);
    chk("irq masked", 32'h0, 32'(irq));
    h.unlock(32'hEB5A70CD);
    apb(0, 12'h014, 0); chk("good key", 32'h1, rd);
    chk("pin dbg", 32'h0, 32'(po));
    goe <= 1; h.level(1'b0); chk("oe dbg", 32'h0, 32'(poe));
    chk("rx follows", 32'h0, 32'(drx));
    goe <= 0; h.level(1'b1);
    chk("irq on", 32'h1, 32'(irq));
    apb(1, 12'h00C, 32'h6); @(posedge pclk); chk("irq off", 32'h0, 32'(irq));
    $display("unlock test done");
  endtask
  task automatic t_break();
    apb(1, 12'h004, 32'h0); pulse(8'h00, 0, 0);
    chk("nop", 32'h1, 32'(nop)); chk("idle", 32'h0, 32'(idle));
    apb(1, 12'h004, 32'h80); @(posedge pclk); chk("entry", 32'h1, 32'(idle));
    apb(1, 12'h004, 32'h40); pulse(8'h01, 0, 0); chk("idle", 32'h0, 32'(idle));
    pulse(8'h00, 0, 0); chk("idle", 32'h1, 32'(idle));
    halt <= 1; hon <= 1;
    apb(0, 12'h000, 0); chk("status", 32'hE0, rd);
    apb(0, 12'h008, 0); a = rd; apb(0, 12'h008, 0); chk("held", a, rd);
    apb(1, 12'h004, 32'h40); apb(0, 12'h008, 0); a = rd;
    apb(0, 12'h008, 0); chk("count", a + 3, rd);
    repeat (65600) @(posedge pclk);
    apb(0, 12'h008, 0); chk("sat", 32'hFFFF, rd);
    apb(0, 12'h00C, 0); chk("sat evt", 32'h9, rd);
    pulse(8'h00, 1, 13'h1ABC);
    chk("strobe", 32'h1, 32'(es)); chk("page", 32'h1A00, 32'(fb));
    $display("break test done");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_key();
    t_break();
    close_out();
  end
endmodule
